//--- core/crm_record_manager.sv
// key-driven store of fifty source/measure records with save, recall, overwrite and clear
//
// What this block does
// - holds up to fifty records, each a source value and measured value pair.
// - source output stays disabled while a record is being recalled.
// - entering memory mode lights slot indicator and preselects slot after highest occupied one.
// - save stores displayed source and measured values, then returns to normal mode.
// - re-entering memory mode after a save preselects the highest occupied slot plus one.
// - empty memory preselects first slot, else slot after highest occupied one.
// - with divided output active and nonzero denominator, stored source is setpoint times numerator over denominator, saturated to all ones.
// - slot up and down keys choose the slot that later actions use.
// - save to occupied slot shows overwrite alarm; second save replaces the record.
// - memory key during overwrite alarm abandons the save, back to memory mode.
// - memory key in memory mode leaves it without storing anything.
// - recall key enters recall state; recall indication blinks throughout.
// - recall shows the slot's stored values, or dashes for an empty slot.
// - memory key or recall key leaves the recall state.
// - save during recall goes to overwrite confirmation for the selected slot.
// - clear shows clear alarm with slot number; second clear erases that slot.
// - memory key during any clear alarm cancels it, back to memory mode.
// - single-slot clear works from the recall state too.
// - down key held five seconds shows erase-all alarm; clear then erases all.
`timescale 1ns/1ns
module crm_record_manager #(
  parameter int HOLD_CYCLES = crm_pkg::ALL_CLEAR_HOLD_CYCLES,
  parameter int BLINK_CYCLES = crm_pkg::BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // front-panel keys, active high while pressed, asynchronous
  input wire logic [crm_pkg::NKEYS-1:0] keyPressed,
  // live values from the source and measure paths
  input wire logic [crm_pkg::VAL_W-1:0] srcSetpoint,
  input wire logic [crm_pkg::VAL_W-1:0] measValue,
  input wire logic divActive,
  input wire logic [crm_pkg::RATIO_W-1:0] divNumerator,
  input wire logic [crm_pkg::RATIO_W-1:0] divDenominator,
  input wire logic srcOutRequest,
  // source output gate
  output logic srcOutEnable,
  // display
  output logic memModeOn,
  output logic slotIndOn,
  output logic [crm_pkg::SLOT_W-1:0] slotNum,
  output logic recallInd,
  output logic overwriteAlarm,
  output logic clearAlarm,
  output logic allClearAlarm,
  output logic dashShown,
  output logic [crm_pkg::VAL_W-1:0] dispSrc,
  output logic [crm_pkg::VAL_W-1:0] dispMeas
);
  import crm_pkg::*;

  // highest occupied slot plus one, wrapping to the first slot when the top is used
  function automatic logic [SLOT_W-1:0] next_free(input logic [SLOTS-1:0] used);
    logic [SLOT_W-1:0] nxt;
    nxt = FIRST_SLOT;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (used[i])
      begin
        nxt = (i == SLOTS - 1) ? FIRST_SLOT : SLOT_W'(i + 1);
      end
    end
    return nxt;
  endfunction

  // key synchronisers and edge detect
  logic [NKEYS-1:0] keyMeta_q;
  logic [NKEYS-1:0] keySync_q;
  logic [NKEYS-1:0] keyPrev_q;
  wire [NKEYS-1:0] keyEdge = keySync_q & ~keyPrev_q;
  wire memKey = keyEdge[KEY_MEM];
  wire saveKey = keyEdge[KEY_SAVE];
  wire readKey = keyEdge[KEY_READ];
  wire clearKey = keyEdge[KEY_CLEAR];
  wire upKey = keyEdge[KEY_UP];
  wire downKey = keyEdge[KEY_DOWN];

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      keyMeta_q <= '0;
      keySync_q <= '0;
      keyPrev_q <= '0;
    end
    else
    begin
      keyMeta_q <= keyPressed;
      keySync_q <= keyMeta_q;
      keyPrev_q <= keySync_q;
    end
  end

  // record storage
  logic [VAL_W-1:0] recSrc_q [0:SLOTS-1];
  logic [VAL_W-1:0] recMeas_q [0:SLOTS-1];
  logic [SLOTS-1:0] used_q;
  crm_state_t state_q;
  crm_state_t state_d;
  logic [SLOT_W-1:0] sel_q;
  logic [SLOT_W-1:0] sel_d;
  logic startCalc;
  logic clearOne;
  logic clearAll;
  logic writeRec;
  // slot stepping and preselection
  wire [SLOT_W-1:0] selUp = (sel_q == LAST_SLOT) ? FIRST_SLOT : sel_q + 6'h01;
  wire [SLOT_W-1:0] selDown = (sel_q == FIRST_SLOT) ? LAST_SLOT : sel_q - 6'h01;
  wire [SLOT_W-1:0] preselect = next_free(used_q);
  wire selUsed = used_q[sel_q];
  // erase-all hold timer
  logic [HOLD_W-1:0] holdCnt_q;
  wire downHeld = keySync_q[KEY_DOWN] && (state_q == ST_MEM);
  wire holdHit = downHeld && (holdCnt_q == HOLD_W'(HOLD_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      holdCnt_q <= '0;
    else if (!downHeld)
      holdCnt_q <= '0;
    else if (holdCnt_q < HOLD_W'(HOLD_CYCLES))
      holdCnt_q <= holdCnt_q + 29'h0000001;
  end

  // scaled source divider: (setpoint * n) / m, restoring, one bit per cycle
  logic [VAL_W-1:0] capSrc_q;
  logic [VAL_W-1:0] capMeas_q;
  logic capScaled_q;
  logic [RATIO_W-1:0] capDen_q;
  logic [PROD_W-1:0] quo_q;
  logic [RATIO_W:0] rem_q;
  logic [4:0] divCnt_q;
  wire [RATIO_W:0] remShift = {rem_q[RATIO_W-1:0], quo_q[PROD_W-1]};
  wire remGe = remShift >= {1'b0, capDen_q};
  wire divDone = (divCnt_q == 5'h00);
  wire [PROD_W-1:0] product = srcSetpoint * divNumerator;
  wire useScaled = divActive && (divDenominator != '0);
  wire [VAL_W-1:0] scaledSrc = (|quo_q[PROD_W-1:VAL_W]) ? '1 : quo_q[VAL_W-1:0];
  wire [VAL_W-1:0] storeSrc = capScaled_q ? scaledSrc : capSrc_q;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      capSrc_q <= '0;
      capMeas_q <= '0;
      capScaled_q <= 1'b0;
      capDen_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      divCnt_q <= '0;
    end
    else if (startCalc)
    begin
      // values on display at the moment of the save press
      capSrc_q <= srcSetpoint;
      capMeas_q <= measValue;
      capScaled_q <= useScaled;
      capDen_q <= divDenominator;
      quo_q <= product;
      rem_q <= '0;
      divCnt_q <= useScaled ? DIV_STEPS : 5'h00;
    end
    else if (!divDone)
    begin
      rem_q <= remGe ? remShift - {1'b0, capDen_q} : remShift;
      quo_q <= {quo_q[PROD_W-2:0], remGe};
      divCnt_q <= divCnt_q - 5'h01;
    end
  end
  // key sequencing
  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    startCalc = 1'b0;
    clearOne = 1'b0;
    clearAll = 1'b0;
    writeRec = 1'b0;
    case (state_q)
      ST_NORMAL:
      begin
        if (memKey)
        begin
          state_d = ST_MEM;
          sel_d = preselect;
        end
      end
      ST_MEM:
      begin
        if (memKey)
          state_d = ST_NORMAL;
        else if (saveKey && selUsed)
          state_d = ST_OVERWRITE;
        else if (saveKey)
        begin
          state_d = ST_CALC;
          startCalc = 1'b1;
        end
        else if (readKey)
          state_d = ST_RECALL;
        else if (clearKey)
          state_d = ST_CLEAR_ONE;
        else if (holdHit)
          state_d = ST_CLEAR_ALL;
        else if (upKey)
          sel_d = selUp;
        else if (downKey)
          sel_d = selDown;
      end
      ST_RECALL:
      begin
        if (memKey || readKey)
          state_d = ST_MEM;
        else if (saveKey)
          state_d = ST_OVERWRITE;
        else if (clearKey)
          state_d = ST_CLEAR_ONE;
        else if (upKey)
          sel_d = selUp;
        else if (downKey)
          sel_d = selDown;
      end
      ST_OVERWRITE:
      begin
        if (memKey)
          state_d = ST_MEM;
        else if (saveKey)
        begin
          state_d = ST_CALC;
          startCalc = 1'b1;
        end
      end
      ST_CLEAR_ONE:
      begin
        if (memKey)
          state_d = ST_MEM;
        else if (clearKey)
        begin
          state_d = ST_MEM;
          clearOne = 1'b1;
        end
      end
      ST_CLEAR_ALL:
      begin
        if (memKey)
          state_d = ST_MEM;
        else if (clearKey)
        begin
          state_d = ST_MEM;
          clearAll = 1'b1;
          sel_d = FIRST_SLOT;
        end
      end
      ST_CALC:
      begin
        if (divDone)
        begin
          writeRec = 1'b1;
          state_d = ST_NORMAL;
        end
      end
      default:
        state_d = ST_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_NORMAL;
      sel_q <= FIRST_SLOT;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
    end
  end

  // one storage entry per slot
  for (genvar g = 0; g < SLOTS; g++)
  begin : gSlot
    wire hitSel = (sel_q == SLOT_W'(g));
    always_ff @(posedge core_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        recSrc_q[g] <= '0;
        recMeas_q[g] <= '0;
        used_q[g] <= 1'b0;
      end
      else if (clearAll || (clearOne && hitSel))
        used_q[g] <= 1'b0;
      else if (writeRec && hitSel)
      begin
        recSrc_q[g] <= storeSrc;
        recMeas_q[g] <= capMeas_q;
        used_q[g] <= 1'b1;
      end
    end
  end

  // recall blink phase
  logic [BLINK_W-1:0] blinkCnt_q;
  logic blinkPhase_q;
  wire recallNext = (state_d == ST_RECALL);
  wire blinkWrap = (blinkCnt_q == BLINK_W'(BLINK_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blinkCnt_q <= '0;
      blinkPhase_q <= 1'b0;
    end
    else if (!recallNext)
    begin
      blinkCnt_q <= '0;
      blinkPhase_q <= 1'b0;
    end
    else if (blinkWrap)
    begin
      blinkCnt_q <= '0;
      blinkPhase_q <= ~blinkPhase_q;
    end
    else
      blinkCnt_q <= blinkCnt_q + 25'h0000001;
  end
  // registered display and output decode
  wire inMemNext = (state_d != ST_NORMAL) && (state_d != ST_CALC);
  wire showRecord = recallNext && used_q[sel_d];
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      srcOutEnable <= 1'b0;
      memModeOn <= 1'b0;
      slotIndOn <= 1'b0;
      slotNum <= FIRST_SLOT;
      recallInd <= 1'b0;
      overwriteAlarm <= 1'b0;
      clearAlarm <= 1'b0;
      allClearAlarm <= 1'b0;
      dashShown <= 1'b0;
      dispSrc <= '0;
      dispMeas <= '0;
    end
    else
    begin
      srcOutEnable <= srcOutRequest && !recallNext;
      memModeOn <= inMemNext;
      slotIndOn <= inMemNext;
      slotNum <= sel_d;
      recallInd <= recallNext && !blinkPhase_q;
      overwriteAlarm <= (state_d == ST_OVERWRITE);
      clearAlarm <= (state_d == ST_CLEAR_ONE);
      allClearAlarm <= (state_d == ST_CLEAR_ALL);
      dashShown <= recallNext && !used_q[sel_d];
      dispSrc <= showRecord ? recSrc_q[sel_d] : (recallNext ? '0 : srcSetpoint);
      dispMeas <= showRecord ? recMeas_q[sel_d] : (recallNext ? '0 : measValue);
    end
  end
endmodule // crm_record_manager

//--- core/crm_pkg.sv
// constants, widths and state type for the calibration record memory manager
package crm_pkg;
  // record store geometry
  localparam int SLOTS = 50;
  localparam int SLOT_W = 6;
  localparam int VAL_W = 16;
  localparam int RATIO_W = 8;
  localparam int PROD_W = VAL_W + RATIO_W;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 6'h00;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 6'h31;
  // key bit positions in the key vector
  localparam int NKEYS = 6;
  localparam int KEY_MEM = 0;
  localparam int KEY_SAVE = 1;
  localparam int KEY_READ = 2;
  localparam int KEY_CLEAR = 3;
  localparam int KEY_UP = 4;
  localparam int KEY_DOWN = 5;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int ALL_CLEAR_HOLD_MS = 5000;
  localparam int ALL_CLEAR_HOLD_CYCLES = ALL_CLEAR_HOLD_MS * CLK_MHZ * 1000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;
  localparam int HOLD_W = 29;
  localparam int BLINK_W = 25;
  // scaled-source divider
  localparam logic [4:0] DIV_STEPS = 5'h18;
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_MEM,
    ST_RECALL,
    ST_OVERWRITE,
    ST_CLEAR_ONE,
    ST_CLEAR_ALL,
    ST_CALC
  } crm_state_t;
endpackage

//--- tb/crm_record_manager_assertions.sv
// port assertions for the record manager
`timescale 1ns/1ns
module crm_record_checker #(
  parameter int HOLD_CYCLES = 50,
  parameter int BLINK_CYCLES = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // inputs
  input wire logic [crm_pkg::NKEYS-1:0] keyPressed,
  input wire logic [crm_pkg::VAL_W-1:0] srcSetpoint,
  input wire logic [crm_pkg::VAL_W-1:0] measValue,
  input wire logic srcOutRequest,
  // outputs
  input wire logic srcOutEnable,
  input wire logic memModeOn,
  input wire logic slotIndOn,
  input wire logic [crm_pkg::SLOT_W-1:0] slotNum,
  input wire logic recallInd,
  input wire logic overwriteAlarm,
  input wire logic clearAlarm,
  input wire logic allClearAlarm,
  input wire logic dashShown,
  input wire logic [crm_pkg::VAL_W-1:0] dispSrc,
  input wire logic [crm_pkg::VAL_W-1:0] dispMeas
);
  import crm_pkg::*;
  logic [31:0] downCnt_q;
  logic [31:0] downCnt_d;
  // cycles the down key pin has been held
  assign downCnt_d = keyPressed[KEY_DOWN] ? downCnt_q + 32'h1 : 32'h0;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      downCnt_q <= 32'h0;
    else
      downCnt_q <= downCnt_d;
  logic [31:0] litCnt_q;
  logic [31:0] litCnt_d;
  // cycles the recall indication has stayed lit without a break
  assign litCnt_d = recallInd ? litCnt_q + 32'h1 : 32'h0;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      litCnt_q <= 32'h0;
    else
      litCnt_q <= litCnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence enterMem;
    !memModeOn ##1 memModeOn;
  endsequence
  gate_off_a: assert property (recallInd |-> !srcOutEnable) else $error("source on in recall");
  gate_req_a: assert property (srcOutEnable |-> $past(srcOutRequest)) else $error("source without request");
  enter_mem_a: assert property (enterMem |-> $past(keyPressed[KEY_MEM], 3)) else $error("mode without key");
  ind_mode_a: assert property (slotIndOn == memModeOn) else $error("slot indicator wrong");
  slot_range_a: assert property (slotNum <= LAST_SLOT) else $error("slot out of range");
  alarm_one_a: assert property ($onehot0({overwriteAlarm, clearAlarm, allClearAlarm})) else $error("two alarms");
  alarm_mode_a: assert property ((overwriteAlarm || clearAlarm || allClearAlarm) |-> memModeOn)
    else $error("alarm outside memory mode");
  dash_zero_a: assert property (dashShown |-> memModeOn && dispSrc == '0 && dispMeas == '0)
    else $error("dash with values");
  disp_live_a: assert property (!memModeOn && $past(rstn) |-> dispSrc == $past(srcSetpoint)
    && dispMeas == $past(measValue)) else $error("live display wrong");
  hold_all_a: assert property ($rose(allClearAlarm) |-> downCnt_q >= HOLD_CYCLES) else $error("erase-all early");
  blink_half_a: assert property (litCnt_q <= BLINK_CYCLES) else $error("recall lit too long");
endmodule // crm_record_checker

//--- tb/crm_panel_model.sv
// front-panel operator model pressing keys
`timescale 1ns/1ns
module crm_panel_model (
  // clock
  input wire logic core_clk,
  // keys toward the manager
  output logic [crm_pkg::NKEYS-1:0] keyPressed
);
  import crm_pkg::*;
  initial keyPressed = '0;
  // held past the synchroniser, then released long enough to read low
  task automatic press(input int k, input int n);
    @(negedge core_clk);
    keyPressed[k] = 1'b1;
    repeat (n) @(negedge core_clk);
    keyPressed[k] = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
endmodule // crm_panel_model

//--- tb/tb_crm_record_manager.sv
// self-checking bench for the record manager
`timescale 1ns/1ns
module tb_crm_record_manager;
  import crm_pkg::*;
  localparam int HOLD = 50;
  localparam int BLINK = 8;
  typedef struct packed {logic [15:0] sp; logic [15:0] mv; logic [5:0] slot;} crm_row_t;
  crm_row_t rows [3] = '{{16'h1234, 16'h0a0b, 6'h00}, {16'h0fff, 16'h8001, 6'h01}, {16'hbeef, 16'h0042, 6'h02}};
  logic core_clk, rstn, divActive, srcOutRequest, s0, s1;
  logic [NKEYS-1:0] keyPressed;
  logic [15:0] srcSetpoint, measValue, dispSrc, dispMeas;
  logic [7:0] divNumerator, divDenominator;
  logic srcOutEnable, memModeOn, slotIndOn, recallInd, overwriteAlarm, clearAlarm, allClearAlarm, dashShown;
  logic [5:0] slotNum;
  int nErrors = 0;
  int totalChecks = 0;
  crm_record_manager #(.HOLD_CYCLES(HOLD), .BLINK_CYCLES(BLINK)) crm_record_manager_i (
    .core_clk, .rstn, .keyPressed, .srcSetpoint, .measValue, .divActive, .divNumerator, .divDenominator,
    .srcOutRequest, .srcOutEnable, .memModeOn, .slotIndOn, .slotNum, .recallInd, .overwriteAlarm,
    .clearAlarm, .allClearAlarm, .dashShown, .dispSrc, .dispMeas);
  crm_panel_model crm_panel_model_i (.core_clk, .keyPressed);
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      nErrors++;
    end
  endtask
  task kp(input int k);
    crm_panel_model_i.press(k, 6);
  endtask
  task completeRun();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #50us;
    nErrors++;
    completeRun();
  end
  initial
  begin
    rstn = 1'b0;
    srcSetpoint = '0;
    measValue = '0;
    divActive = 1'b0;
    divNumerator = 8'h03;
    divDenominator = 8'h04;
    srcOutRequest = 1'b1;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    chk("slot", slotNum, 6'h00);
    for (int i = 0; i < 3; i++)
    begin
      srcSetpoint = rows[i].sp;
      measValue = rows[i].mv;
      kp(KEY_MEM);
      chk("slot", slotNum, rows[i].slot);
      chk("ind", slotIndOn, 1'b1);
      kp(KEY_SAVE);
      chk("mode", memModeOn, 1'b0);
    end
    kp(KEY_MEM);
    kp(KEY_DOWN);
    chk("slot", slotNum, 6'h02);
    kp(KEY_READ);
    chk("srcOut", srcOutEnable, 1'b0);
    chk("dispSrc", dispSrc, rows[2].sp);
    chk("dispMeas", dispMeas, rows[2].mv);
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (3 * BLINK)
    begin
      @(negedge core_clk);
      s0 |= !recallInd;
      s1 |= recallInd;
    end
    chk("blink", {s0, s1}, 2'b11);
    kp(KEY_SAVE);
    chk("owAlarm", overwriteAlarm, 1'b1);
    kp(KEY_MEM);
    chk("owAlarm", overwriteAlarm, 1'b0);
    chk("mode", memModeOn, 1'b1);
    divActive = 1'b1;
    srcSetpoint = 16'h0100;
    measValue = 16'h5555;
    kp(KEY_SAVE);
    chk("owAlarm", overwriteAlarm, 1'b1);
    kp(KEY_SAVE);
    repeat (30) @(negedge core_clk);
    chk("mode", memModeOn, 1'b0);
    divActive = 1'b0;
    kp(KEY_MEM);
    chk("slot", slotNum, 6'h03);
    kp(KEY_DOWN);
    kp(KEY_READ);
    chk("dispSrc", dispSrc, 16'h00c0);
    chk("dispMeas", dispMeas, 16'h5555);
    kp(KEY_READ);
    chk("mode", memModeOn, 1'b1);
    chk("srcOut", srcOutEnable, 1'b1);
    kp(KEY_DOWN);
    kp(KEY_READ);
    kp(KEY_CLEAR);
    chk("clrAlarm", clearAlarm, 1'b1);
    chk("slot", slotNum, 6'h01);
    kp(KEY_MEM);
    chk("clrAlarm", clearAlarm, 1'b0);
    chk("mode", memModeOn, 1'b1);
    kp(KEY_CLEAR);
    kp(KEY_CLEAR);
    chk("clrAlarm", clearAlarm, 1'b0);
    kp(KEY_READ);
    chk("dash", dashShown, 1'b1);
    kp(KEY_MEM);
    chk("mode", memModeOn, 1'b1);
    kp(KEY_MEM);
    chk("mode", memModeOn, 1'b0);
    kp(KEY_MEM);
    chk("slot", slotNum, 6'h03);
    crm_panel_model_i.press(KEY_DOWN, HOLD + 10);
    chk("allAlarm", allClearAlarm, 1'b1);
    kp(KEY_CLEAR);
    chk("allAlarm", allClearAlarm, 1'b0);
    chk("slot", slotNum, 6'h00);
    kp(KEY_DOWN);
    chk("slot", slotNum, LAST_SLOT);
    kp(KEY_MEM);
    kp(KEY_MEM);
    chk("slot", slotNum, 6'h00);
    kp(KEY_READ);
    chk("dash", dashShown, 1'b1);
    kp(KEY_MEM);
    divActive = 1'b1;
    divDenominator = 8'h00;
    srcSetpoint = 16'h7777;
    measValue = 16'h1111;
    kp(KEY_SAVE);
    chk("mode", memModeOn, 1'b0);
    divNumerator = 8'hff;
    divDenominator = 8'h01;
    srcSetpoint = 16'hffff;
    kp(KEY_MEM);
    kp(KEY_SAVE);
    repeat (30) @(negedge core_clk);
    divActive = 1'b0;
    kp(KEY_MEM);
    chk("slot", slotNum, 6'h02);
    kp(KEY_DOWN);
    kp(KEY_READ);
    chk("dispSrc", dispSrc, 16'hffff);
    kp(KEY_DOWN);
    chk("dispSrc", dispSrc, 16'h7777);
    chk("dispMeas", dispMeas, 16'h1111);
    kp(KEY_MEM);
    crm_panel_model_i.press(KEY_DOWN, HOLD + 10);
    chk("allAlarm", allClearAlarm, 1'b1);
    kp(KEY_MEM);
    chk("allAlarm", allClearAlarm, 1'b0);
    chk("mode", memModeOn, 1'b1);
    kp(KEY_UP);
    kp(KEY_READ);
    chk("dispSrc", dispSrc, 16'h7777);
    kp(KEY_READ);
    srcOutRequest = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("srcOut", srcOutEnable, 1'b0);
    srcOutRequest = 1'b1;
    rstn = 1'b0;
    @(negedge core_clk);
    chk("ind", slotIndOn, 1'b0);
    rstn = 1'b1;
    kp(KEY_MEM);
    chk("slot", slotNum, 6'h00);
    kp(KEY_READ);
    chk("dash", dashShown, 1'b1);
    completeRun();
  end
endmodule // tb_crm_record_manager
bind crm_record_manager crm_record_checker #(.HOLD_CYCLES(HOLD_CYCLES), .BLINK_CYCLES(BLINK_CYCLES))
  crm_record_checker_i (.core_clk, .rstn, .keyPressed, .srcSetpoint, .measValue, .srcOutRequest,
  .srcOutEnable, .memModeOn, .slotIndOn, .slotNum, .recallInd, .overwriteAlarm, .clearAlarm,
  .allClearAlarm, .dashShown, .dispSrc, .dispMeas);
